// *** rtl/core_timing_consts.vh ***
`ifndef CORE_TIMING_CONSTS_VH
`define CORE_TIMING_CONSTS_VH

// ****************************************************************
// Special function register addresses and reset values.
// ****************************************************************
`define PTR_LOW_ADDR      8'h82
`define PTR_HIGH_ADDR     8'h83
`define PTR_RESET         8'h00
`define SFR_BASE          8'h80

// ****************************************************************
// Opcodes used for special decode.
// ****************************************************************
`define OP_SPARE_NOP      8'ha5
`define OP_NOP            8'h00
`define OP_LONG_JUMP      8'h02
`define OP_LONG_CALL      8'h12
`define OP_SHORT_JUMP     8'h80
`define OP_IND_JUMP       8'h73
`define OP_PTR_INC        8'ha3
`define OP_PTR_LOAD       8'h90
`define OP_CODE_RD_PTR    8'h93
`define OP_CODE_RD_PC     8'h83
`define OP_JBC            8'h10

// ****************************************************************
// Cycle counts.
// ****************************************************************
`define CYC_ONE           4'd1
`define CYC_TWO           4'd2
`define CYC_THREE         4'd3
`define CYC_FOUR          4'd4
`define CYC_FIVE          4'd5
`define CYC_EIGHT         4'd8

`endif

// *** rtl/timing_rom.v ***
`default_nettype none

// ****************************************************************
// Opcode length and timing lookup, registered output.
// ****************************************************************
module timing_rom (
  // Clock and reset.
  input  wire       core_clk_i,
  input  wire       rst_b_i,
  // Lookup.
  input  wire [7:0] opcode_i,
  output reg  [1:0] length_o,
  output reg  [3:0] base_cycles_o,
  output reg        is_branch_o
);

  reg [1:0] len;
  reg [3:0] cyc;
  reg       br;

  // Decode table; conditional branches give the not-taken count.
  always @* begin
    len = 2'd1;
    cyc = 4'd1;
    br  = 1'b0;
    casez (opcode_i)
      8'b???0_0001: begin len = 2'd2; cyc = 4'd3; end
      8'b???1_0001: begin len = 2'd2; cyc = 4'd3; end
      8'h02, 8'h12: begin len = 2'd3; cyc = 4'd4; end
      8'h80:        begin len = 2'd2; cyc = 4'd3; end
      8'h73, 8'h93, 8'h83: begin len = 2'd1; cyc = 4'd3; end
      8'he0, 8'he2, 8'he3, 8'hf0, 8'hf2, 8'hf3: begin
        len = 2'd1; cyc = 4'd3; end
      8'h85, 8'h75, 8'h90, 8'h43, 8'h53, 8'h63: begin
        len = 2'd3; cyc = 4'd3; end
      8'hc0, 8'hd0: begin len = 2'd2; cyc = 4'd2; end
      8'hd6, 8'hd7, 8'he6, 8'he7, 8'hf6, 8'hf7, 8'hc6, 8'hc7: begin
        len = 2'd1; cyc = 4'd2; end
      8'h40, 8'h50, 8'h60, 8'h70: begin
        len = 2'd2; cyc = 4'd2; br = 1'b1; end
      8'h10, 8'h20, 8'h30: begin len = 2'd3; cyc = 4'd3; br = 1'b1; end
      8'hb5, 8'hb6, 8'hb7: begin len = 2'd3; cyc = 4'd4; br = 1'b1; end
      8'hb4, 8'b1011_1???: begin len = 2'd3; cyc = 4'd3; br = 1'b1; end
      8'b1101_1???: begin len = 2'd2; cyc = 4'd2; br = 1'b1; end
      8'hd5:        begin len = 2'd3; cyc = 4'd3; br = 1'b1; end
      8'hb2, 8'hc2, 8'hd2, 8'h82, 8'hb0, 8'h72, 8'ha0, 8'ha2, 8'h92: begin
        len = 2'd2; cyc = 4'd2; end
      8'h22, 8'h32: begin len = 2'd1; cyc = 4'd5; end
      8'ha4:        begin len = 2'd1; cyc = 4'd4; end
      8'h84:        begin len = 2'd1; cyc = 4'd8; end
      8'h86, 8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'h8e, 8'h8f,
      8'ha6, 8'ha7, 8'ha8, 8'ha9, 8'haa, 8'hab, 8'hac, 8'had, 8'hae,
      8'haf, 8'h76, 8'h77, 8'h78, 8'h79, 8'h7a, 8'h7b, 8'h7c, 8'h7d,
      8'h7e, 8'h7f, 8'he5, 8'h74, 8'hf5, 8'hc5, 8'he8, 8'he9, 8'hea,
      8'heb, 8'hec, 8'hed, 8'hee, 8'hef, 8'hc8, 8'hc9, 8'hca, 8'hcb,
      8'hcc, 8'hcd, 8'hce, 8'hcf: begin
        len = (opcode_i[7:3] == 5'b11101 || opcode_i[7:3] == 5'b11001)
              ? 2'd1 : 2'd2;
        cyc = (opcode_i[7:3] == 5'b11101 || opcode_i[7:3] == 5'b11001)
              ? 4'd1 : 4'd2;
      end
      default:      begin len = 2'd1; cyc = 4'd1; end
    endcase
  end

  // Register the lookup so the sequencer reads a flop.
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      length_o      <= 2'd1;
      base_cycles_o <= 4'd1;
      is_branch_o   <= 1'b0;
    end else begin
      length_o      <= len;
      base_cycles_o <= cyc;
      is_branch_o   <= br;
    end
  end

endmodule

`default_nettype wire

// *** rtl/pointer_regs.v ***
`default_nettype none
`include "core_timing_consts.vh"

// ****************************************************************
// Sixteen-bit data pointer as two special function registers.
// ****************************************************************
module pointer_regs (
  // Clock and reset.
  input  wire        core_clk_i,
  input  wire        rst_b_i,
  // Register access.
  input  wire        sfr_wr_i,
  input  wire [7:0]  sfr_addr_i,
  input  wire [7:0]  sfr_wdata_i,
  // Core updates.
  input  wire        inc_i,
  input  wire        load_i,
  input  wire [15:0] load_value_i,
  // Pointer value.
  output reg  [15:0] data_pointer_o
);

  // Increment carries from low byte into high byte as one counter.
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      data_pointer_o <= {`PTR_RESET, `PTR_RESET}; // RQ21 RQ23
    end else if (load_i) begin
      data_pointer_o <= load_value_i;
    end else if (inc_i) begin
      data_pointer_o <= data_pointer_o + 16'h0001; // RQ25
    end else if (sfr_wr_i && sfr_addr_i == `PTR_LOW_ADDR) begin
      data_pointer_o[7:0] <= sfr_wdata_i; // RQ21
    end else if (sfr_wr_i && sfr_addr_i == `PTR_HIGH_ADDR) begin
      data_pointer_o[15:8] <= sfr_wdata_i; // RQ23
    end
  end

endmodule

`default_nettype wire

// *** rtl/instr_sequencer.v ***
// Functional notes
// (RQ1) Accumulator clear, complement, rotates and swap finish in one cycle.
// (RQ2) Direct-to-direct and immediate-to-direct moves take three cycles.
// (RQ3) Accumulator moves with indirect RAM take two cycles.
// (RQ4) Code byte reads use accumulator plus pointer or PC, three cycles.
// (RQ5) External moves use 8-bit or 16-bit address, three cycles.
// (RQ6) Stack push and pop take two bytes, two cycles.
// (RQ7) Low nibble exchange swaps low four bits in two cycles.
// (RQ8) Carry ops one cycle; direct bit ops two bytes, two cycles.
// (RQ9) Carry and zero jumps take two cycles, three when taken.
// (RQ10) Bit jumps take three or four cycles; test-and-clear clears set bit.
// (RQ11) Long call and jump carry 16-bit target, four cycles.
// (RQ12) Page call and jump replace low 11 bits, three cycles.
// (RQ13) Short jump always takes three cycles.
// (RQ14) Relative offsets are signed 8-bit, added to next address.
// (RQ15) Compare jumps: direct or indirect 4/5, immediate 3/4 cycles.
// (RQ16) Decrement jumps: register 2/3, direct 3/4 cycles.
// (RQ17) Indirect jump goes to accumulator plus pointer, three cycles.
// (RQ18) Spare opcode behaves exactly as no-operation.
// (RQ19) Direct addresses below 0x80 are RAM, above are registers.
// (RQ20) Indirect uses bank registers 0 and 1; bank operands use current bank.
// (RQ21) Pointer low byte at 0x82, read/write, resets to zero.
// (RQ22) Software writes zero to reserved bits; reserved read zero.
// (RQ23) Pointer high byte at 0x83, read/write, resets to zero.
// (RQ24) Branches not taken finish one cycle sooner than taken.
// (RQ25) Pointer increment carries from low into high byte.
`default_nettype none
`include "core_timing_consts.vh"

module instr_sequencer (
  // Clock and reset.
  input  wire        core_clk_i,
  input  wire        rst_b_i,
  // Instruction stream.
  input  wire        instr_valid_i,
  input  wire [7:0]  opcode_i,
  input  wire [7:0]  operand1_i,
  input  wire [7:0]  operand2_i,
  input  wire [15:0] pc_i,
  // Core state.
  input  wire [7:0]  acc_i,
  input  wire        carry_i,
  input  wire        bit_value_i,
  input  wire [7:0]  cmp_value_i,
  input  wire [7:0]  dec_value_i,
  input  wire [1:0]  bank_select_i,
  // Register access.
  input  wire        sfr_wr_i,
  input  wire        sfr_rd_i,
  input  wire [7:0]  sfr_addr_i,
  input  wire [7:0]  sfr_wdata_i,
  output reg  [7:0]  sfr_rdata_o,
  // Sequencing results.
  output reg         busy_o,
  output reg         done_o,
  output reg  [3:0]  cycles_o,
  output reg  [1:0]  length_o,
  output reg         taken_o,
  output reg  [15:0] next_pc_o,
  output reg         bit_clear_o,
  output reg  [15:0] mem_addr_o,
  output reg         direct_is_sfr_o,
  output reg  [4:0]  ram_index_o,
  output reg         nop_o
);

  // ****************************************************************
  // State and lookup.
  // ****************************************************************
  localparam ST_IDLE = 1'b0;
  localparam ST_RUN  = 1'b1;

  // Captured copy of the instruction and of the core state it depends on.
  // Holding them keeps the answer steady while the core moves on.
  reg        state;
  reg [7:0]  op;
  reg [7:0]  opr1;
  reg [7:0]  opr2;
  reg [15:0] pc;
  reg [7:0]  acc;
  reg        cy;
  reg        bitv;
  reg [7:0]  cmpv;
  reg [7:0]  decv;
  reg [1:0]  bank;
  reg [3:0]  count;
  reg        load_now;
  wire [1:0] rom_len;
  wire [3:0] rom_cyc;
  wire       rom_br;
  wire [15:0] data_pointer;

  // Combinational decode results, only latched on the first run cycle.
  reg        take;
  reg        ptr_inc;
  reg        ptr_load;
  reg [3:0]  total;
  reg [15:0] nxt;
  reg [15:0] target;
  reg [15:0] addr;

  // Sign-extend a relative offset onto the next instruction address.
  function [15:0] rel_target;
    input [15:0] next_addr;
    input [7:0]  offs;
    begin
      rel_target = next_addr + {{8{offs[7]}}, offs}; // RQ14
    end
  endfunction

  // The lookup sees the live opcode, so its registered answer lines up
  // with the captured instruction on the cycle after acceptance.
  timing_rom u_rom (
    .core_clk_i    (core_clk_i),
    .rst_b_i       (rst_b_i),
    .opcode_i      (opcode_i),
    .length_o      (rom_len),
    .base_cycles_o (rom_cyc),
    .is_branch_o   (rom_br)
  );

  // The pointer bytes live apart so that register writes and core
  // updates share one counter with a single priority order.
  pointer_regs u_ptr (
    .core_clk_i     (core_clk_i),
    .rst_b_i        (rst_b_i),
    .sfr_wr_i       (sfr_wr_i),
    .sfr_addr_i     (sfr_addr_i),
    .sfr_wdata_i    (sfr_wdata_i),
    .inc_i          (ptr_inc),
    .load_i         (ptr_load),
    .load_value_i   ({opr1, opr2}),
    .data_pointer_o (data_pointer)
  );

  // ****************************************************************
  // Branch decision and target, evaluated on the captured instruction.
  // ****************************************************************
  always @* begin
    nxt      = pc + {14'h0000, rom_len};
    take     = 1'b0;
    target   = nxt;
    addr     = 16'h0000;
    ptr_inc  = load_now && (op == `OP_PTR_INC);
    ptr_load = load_now && (op == `OP_PTR_LOAD);
    casez (op)
      8'h40: take = cy; // RQ9
      8'h50: take = !cy;
      8'h60: take = (acc == 8'h00);
      8'h70: take = (acc != 8'h00);
      8'h20, 8'h10: take = bitv; // RQ10
      8'h30: take = !bitv;
      // The accumulator forms compare the accumulator; the direct form
      // takes the direct byte on the compare input, the others take the
      // bank or indirect value there and compare it with the immediate.
      8'hb4: take = (acc != opr1); // RQ15
      8'hb5: take = (acc != cmpv); // RQ15
      8'hb6, 8'hb7, 8'b1011_1???:
        take = (cmpv != opr1); // RQ15
      8'b1101_1???, 8'hd5: take = (decv != 8'h01); // RQ16
      8'h80: take = 1'b1; // RQ13
      default: take = 1'b0;
    endcase
    if (op == 8'h20 || op == 8'h30 || op == `OP_JBC ||
        op[7:4] == 4'hb && op != 8'hb0 && op != 8'hb2 && op != 8'hb3 ||
        op == 8'hd5)
      target = rel_target(nxt, opr2);
    else
      target = rel_target(nxt, opr1);
    if (op == `OP_LONG_JUMP || op == `OP_LONG_CALL) begin
      take   = 1'b1;
      target = {opr1, opr2}; // RQ11
    end
    if (op[4:0] == 5'b00001 || op[4:0] == 5'b10001) begin
      take   = 1'b1;
      target = {nxt[15:11], op[7:5], opr1}; // RQ12
    end
    if (op == `OP_IND_JUMP) begin
      take   = 1'b1;
      target = data_pointer + {8'h00, acc}; // RQ17
    end
    // Memory address for code reads and external moves; other
    // instructions leave it at zero so a stale address is never shown.
    if (op == `OP_CODE_RD_PTR)
      addr = data_pointer + {8'h00, acc}; // RQ4
    else if (op == `OP_CODE_RD_PC)
      addr = nxt + {8'h00, acc};
    else if (op == 8'he0 || op == 8'hf0)
      addr = data_pointer; // RQ5
    else if (op == 8'he2 || op == 8'he3 || op == 8'hf2 || op == 8'hf3)
      addr = {8'h00, opr1};
    // The table holds the not-taken count; a taken branch adds one.
    total = rom_cyc + ((rom_br && take) ? 4'd1 : 4'd0); // RQ24
  end

  // ****************************************************************
  // Capture and count up the cycles of each instruction.
  // ****************************************************************
  // The lookup flop lags one cycle, so results are issued on the cycle
  // after capture; a new instruction is only accepted while idle.
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      // Every output starts at zero so nothing looks finished after reset.
      state <= ST_IDLE;
      op <= 8'h00;
      opr1 <= 8'h00;
      opr2 <= 8'h00;
      pc <= 16'h0000;
      acc <= 8'h00;
      cy <= 1'b0;
      bitv <= 1'b0;
      cmpv <= 8'h00;
      decv <= 8'h00;
      bank <= 2'b00;
      count <= 4'd0;
      load_now <= 1'b0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      cycles_o <= 4'd0;
      length_o <= 2'd0;
      taken_o <= 1'b0;
      next_pc_o <= 16'h0000;
      bit_clear_o <= 1'b0;
      mem_addr_o <= 16'h0000;
      direct_is_sfr_o <= 1'b0;
      ram_index_o <= 5'd0;
      nop_o <= 1'b0;
    end else begin
      load_now <= 1'b0;
      done_o   <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (instr_valid_i) begin
            // Capture all inputs at once; later changes on the pins do
            // not disturb the instruction in flight.
            op <= opcode_i;
            opr1 <= operand1_i;
            opr2 <= operand2_i;
            pc <= pc_i;
            acc <= acc_i;
            cy <= carry_i;
            bitv <= bit_value_i;
            cmpv <= cmp_value_i;
            decv <= dec_value_i;
            bank <= bank_select_i;
            load_now <= 1'b1;
            busy_o   <= 1'b1;
            state    <= ST_RUN;
            count    <= 4'd0;
          end
        end
        ST_RUN: begin
          if (load_now) begin
            cycles_o   <= total; // RQ1 RQ2 RQ3 RQ6 RQ7 RQ8
            length_o   <= rom_len;
            taken_o    <= take;
            next_pc_o  <= take ? target : nxt;
            mem_addr_o <= addr;
            bit_clear_o <= (op == `OP_JBC) && bitv; // RQ10
            direct_is_sfr_o <= (opr1 >= `SFR_BASE); // RQ19
            // Indirect forms use only the two lowest bank registers.
            ram_index_o <= {bank, (op[3] ? op[2:0] : {2'b00, op[0]})};// RQ20
            nop_o <= (op == `OP_NOP) || (op == `OP_SPARE_NOP); // RQ18
            count <= 4'd1;
            if (total <= 4'd1) begin
              done_o <= 1'b1;
              busy_o <= 1'b0;
              state  <= ST_IDLE;
            end
          end else begin
            count <= count + 4'd1;
            if (count + 4'd1 >= cycles_o) begin
              done_o <= 1'b1;
              busy_o <= 1'b0;
              state  <= ST_IDLE;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Register read path; unmapped and reserved bits read as zero.
  // ****************************************************************
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sfr_rdata_o <= 8'h00;
    end else if (sfr_rd_i && sfr_addr_i == `PTR_LOW_ADDR) begin
      sfr_rdata_o <= data_pointer[7:0]; // RQ21
    end else if (sfr_rd_i && sfr_addr_i == `PTR_HIGH_ADDR) begin
      sfr_rdata_o <= data_pointer[15:8]; // RQ23
    end else begin
      sfr_rdata_o <= 8'h00; // RQ22
    end
  end

endmodule

`default_nettype wire

// *** testbench/seq_asserts.sv ***
`default_nettype none
module seq_asserts (
  // Clock and reset.
  input wire logic       core_clk_i,
  input wire logic       rst_b_i,
  // Watched ports.
  input wire logic       instr_valid_i,
  input wire logic [7:0] opcode_i,
  input wire logic [7:0] operand1_i,
  input wire logic       sfr_rd_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic       busy_o,
  input wire logic       done_o,
  input wire logic [3:0] cycles_o,
  input wire logic [1:0] length_o,
  input wire logic       taken_o,
  input wire logic       direct_is_sfr_o,
  input wire logic       nop_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  // An instruction is accepted only while the sequencer is idle.
  wire logic tk = instr_valid_i && !busy_o;
  // ****************************************************************
  // Completion sequences measured from the first result edge.
  // ****************************************************************
  // Results are written on the edge after acceptance, so they are first
  // sampled two edges after it.
  sequence s_three; !done_o ##1 !done_o ##1 done_o; endsequence
  sequence s_four; !done_o [*3] ##1 done_o; endsequence
  property p_acc; tk && opcode_i == 8'he4 |=> ##1 done_o && cycles_o == 1;
  endproperty
  property p_spare; tk && opcode_i == 8'ha5 |=> ##1 nop_o && length_o == 1;
  endproperty
  property p_long; tk && (opcode_i == 8'h02 || opcode_i == 8'h12)
    |=> ##1 cycles_o == 4 ##0 s_four; endproperty
  property p_short; tk && opcode_i == 8'h80
    |=> ##1 taken_o && cycles_o == 3 ##0 s_three; endproperty
  property p_cond; tk && opcode_i[7:4] inside {4'h4, 4'h5, 4'h6, 4'h7}
    && opcode_i[3:0] == 4'h0 |=> ##1 cycles_o == (taken_o ? 4'd3 : 4'd2);
  endproperty
  property p_bit; tk && opcode_i == 8'h20
    |=> ##1 cycles_o == (taken_o ? 4'd4 : 4'd3); endproperty
  property p_cmp; tk && opcode_i == 8'hb5
    |=> ##1 cycles_o == (taken_o ? 4'd5 : 4'd4); endproperty
  property p_dec; tk && opcode_i == 8'hd8
    |=> ##1 cycles_o == (taken_o ? 4'd3 : 4'd2); endproperty
  property p_dir; tk |=> ##1 direct_is_sfr_o == $past(operand1_i[7], 2);
  endproperty
  property p_unmap; sfr_rd_i && sfr_addr_i == 8'h81 |=> sfr_rdata_o == 0;
  endproperty
  a_acc: assert property (p_acc) else $error("acc op not one cycle");
  a_spare: assert property (p_spare) else $error("spare op not nop");
  a_long: assert property (p_long) else $error("long jump timing");
  a_short: assert property (p_short) else $error("short jump timing");
  a_cond: assert property (p_cond) else $error("cond jump cycles");
  a_bit: assert property (p_bit) else $error("bit jump cycles");
  a_cmp: assert property (p_cmp) else $error("compare jump cycles");
  a_dec: assert property (p_dec) else $error("decrement jump cycles");
  a_dir: assert property (p_dir) else $error("direct space select");
  a_unmap: assert property (p_unmap) else $error("unmapped read");
endmodule
bind instr_sequencer seq_asserts seq_asserts_i (.core_clk_i, .rst_b_i,
  .instr_valid_i, .opcode_i, .operand1_i, .sfr_rd_i, .sfr_addr_i,
  .sfr_rdata_o, .busy_o, .done_o, .cycles_o, .length_o, .taken_o,
  .direct_is_sfr_o, .nop_o);
`default_nettype wire

// *** testbench/ext_mem_model.sv ***
`default_nettype none
module ext_mem_model (
  // Clock and reset.
  input  wire logic        core_clk_i,
  input  wire logic        rst_b_i,
  // Access seen from the core.
  input  wire logic        done_i,
  input  wire logic [15:0] addr_i,
  output var  logic [15:0] last_addr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // The memory latches the address of each finished access, so the bench
  // sees what really reached the bus rather than a live, moving value.
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      last_addr_o <= 16'h0000;
    end else if (done_i) begin
      last_addr_o <= addr_i;
    end
  end
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] P = 16'h17fe;
  logic        clk, rst_b, valid, cy, bitv, wr, rd;
  logic [7:0]  op, op1, op2, acc, cmpv, decv, addr, wdata;
  logic [1:0]  bank;
  wire logic [7:0]  rdata;
  wire logic        busy, done, taken, bclr, dsfr, no_operation;
  wire logic [3:0]  cyc;
  wire logic [1:0]  len;
  wire logic [4:0]  ridx;
  wire logic [15:0] npc, maddr, last;
  int          err_count, tests_run;
  instr_sequencer instr_sequencer_i (.core_clk_i(clk), .rst_b_i(rst_b),
    .instr_valid_i(valid), .opcode_i(op), .operand1_i(op1),
    .operand2_i(op2), .pc_i(P), .acc_i(acc), .carry_i(cy),
    .bit_value_i(bitv), .cmp_value_i(cmpv), .dec_value_i(decv),
    .bank_select_i(bank), .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_addr_i(addr),
    .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .busy_o(busy), .done_o(done),
    .cycles_o(cyc), .length_o(len), .taken_o(taken), .next_pc_o(npc),
    .bit_clear_o(bclr), .mem_addr_o(maddr), .direct_is_sfr_o(dsfr),
    .ram_index_o(ridx), .nop_o(no_operation));
  ext_mem_model ext_mem_model_i (.core_clk_i(clk), .rst_b_i(rst_b),
    .done_i(done), .addr_i(maddr), .last_addr_o(last));
  // ****************************************************************
  // Checking and bus tasks.
  // ****************************************************************
  task automatic chk(input string n, input logic [15:0] e, g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // Offers one instruction and counts edges until done, bounded at 12.
  task automatic ex(input logic [7:0] o, a, b, input logic [3:0] c,
                    input logic [1:0] l, input logic t, input logic [15:0] pn);
    int n;
    op = o;
    op1 = a;
    op2 = b;
    valid = 1'b1;
    @(posedge clk);
    #1 valid = 1'b0;
    chk("busy_o", 1, busy);
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (done !== 1'b1 && n < 12);
    chk("cycles seen", c, 16'(n));
    chk("busy_o", 0, busy);
    chk("cycles_o", c, cyc);
    chk("length_o", l, len);
    chk("taken_o", t, taken);
    chk("next_pc_o", pn, npc);
  endtask
  task automatic sw(input logic [7:0] a, d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge clk);
    #1 wr = 1'b0;
  endtask
  task automatic sr(input logic [7:0] a, e);
    addr = a;
    rd = 1'b1;
    @(posedge clk);
    #1 rd = 1'b0;
    chk("sfr_rdata_o", e, rdata);
  endtask
  // The memory model latches on the edge after done, so look then.
  task automatic cm(input string n, input logic [15:0] e);
    @(posedge clk);
    #1 chk(n, e, last);
  endtask
  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic t_acc;
    logic [7:0] ops [10] = '{8'he4, 8'hf4, 8'h23, 8'h33, 8'h03, 8'h13,
                             8'hc4, 8'hc3, 8'hd3, 8'hb3};
    foreach (ops[i]) ex(ops[i], 8'h00, 8'h00, 1, 1, 0, P + 1);
    ex(8'h00, 8'h00, 8'h00, 1, 1, 0, P + 1);
    ex(8'ha5, 8'h00, 8'h00, 1, 1, 0, P + 1);
    chk("nop_o", 1, no_operation);
    $display("test acc done");
  endtask
  task automatic t_moves;
    ex(8'h85, 8'h30, 8'h90, 3, 3, 0, P + 3);
    ex(8'h75, 8'h30, 8'h55, 3, 3, 0, P + 3);
    ex(8'he6, 8'h00, 8'h00, 2, 1, 0, P + 1);
    ex(8'hf7, 8'h00, 8'h00, 2, 1, 0, P + 1);
    ex(8'hc0, 8'he0, 8'h00, 2, 2, 0, P + 2);
    ex(8'hd0, 8'he0, 8'h00, 2, 2, 0, P + 2);
    ex(8'hd6, 8'h00, 8'h00, 2, 1, 0, P + 1);
    ex(8'hb0, 8'h21, 8'h00, 2, 2, 0, P + 2);
    ex(8'hc2, 8'h21, 8'h00, 2, 2, 0, P + 2);
    $display("test moves done");
  endtask
  task automatic t_ptr;
    sr(8'h82, 8'h00);
    sr(8'h83, 8'h00);
    sw(8'h82, 8'hab);
    sw(8'h83, 8'hcd);
    sr(8'h82, 8'hab);
    sr(8'h83, 8'hcd);
    sr(8'h81, 8'h00);
    ex(8'h90, 8'h12, 8'hff, 3, 3, 0, P + 3);
    ex(8'ha3, 8'h00, 8'h00, 1, 1, 0, P + 1);
    sr(8'h83, 8'h13);
    sr(8'h82, 8'h00);
    acc = 8'h05;
    ex(8'h93, 8'h00, 8'h00, 3, 1, 0, P + 1);
    cm("code address", 16'h1305);
    ex(8'h83, 8'h00, 8'h00, 3, 1, 0, P + 1);
    cm("code address", P + 1 + 5);
    ex(8'he0, 8'h00, 8'h00, 3, 1, 0, P + 1);
    cm("ext address", 16'h1300);
    ex(8'hf0, 8'h00, 8'h00, 3, 1, 0, P + 1);
    ex(8'he2, 8'h00, 8'h00, 3, 1, 0, P + 1);
    ex(8'hf2, 8'h00, 8'h00, 3, 1, 0, P + 1);
    ex(8'h73, 8'h00, 8'h00, 3, 1, 1, 16'h1305);
    $display("test pointer done");
  endtask
  task automatic t_cond;
    cy = 1'b0;
    ex(8'h40, 8'hfe, 8'h00, 2, 2, 0, P + 2);
    cy = 1'b1;
    ex(8'h40, 8'hfe, 8'h00, 3, 2, 1, P);
    ex(8'h50, 8'hfe, 8'h00, 2, 2, 0, P + 2);
    acc = 8'h00;
    ex(8'h60, 8'h10, 8'h00, 3, 2, 1, 16'h1810);
    ex(8'h70, 8'h10, 8'h00, 2, 2, 0, P + 2);
    bitv = 1'b1;
    ex(8'h20, 8'h21, 8'h10, 4, 3, 1, 16'h1811);
    ex(8'h30, 8'h21, 8'h10, 3, 3, 0, P + 3);
    ex(8'h10, 8'h21, 8'h10, 4, 3, 1, 16'h1811);
    chk("bit_clear_o", 1, bclr);
    bitv = 1'b0;
    ex(8'h10, 8'h21, 8'h10, 3, 3, 0, P + 3);
    chk("bit_clear_o", 0, bclr);
    acc = 8'h05;
    cmpv = 8'h05;
    ex(8'hb5, 8'h30, 8'h10, 4, 3, 0, P + 3);
    ex(8'hb6, 8'h05, 8'h10, 4, 3, 0, P + 3);
    cmpv = 8'h06;
    ex(8'hb5, 8'h30, 8'h10, 5, 3, 1, 16'h1811);
    ex(8'hb4, 8'h06, 8'h10, 4, 3, 1, 16'h1811);
    acc = 8'h07;
    cmpv = 8'h07;
    ex(8'hb8, 8'h07, 8'h10, 3, 3, 0, P + 3);
    decv = 8'h01;
    ex(8'hd8, 8'hfe, 8'h00, 2, 2, 0, P + 2);
    decv = 8'h00;
    ex(8'hd8, 8'hfe, 8'h00, 3, 2, 1, P);
    decv = 8'h02;
    ex(8'hd5, 8'h30, 8'hfe, 4, 3, 1, P + 1);
    $display("test branches done");
  endtask
  task automatic t_jump;
    ex(8'h02, 8'h12, 8'h34, 4, 3, 1, 16'h1234);
    ex(8'h12, 8'hab, 8'hcd, 4, 3, 1, 16'habcd);
    ex(8'h01, 8'h34, 8'h00, 3, 2, 1, 16'h1834);
    ex(8'h31, 8'h34, 8'h00, 3, 2, 1, 16'h1934);
    ex(8'h80, 8'h80, 8'h00, 3, 2, 1, 16'h1780);
    $display("test jumps done");
  endtask
  task automatic t_addr;
    ex(8'he5, 8'h7f, 8'h00, 2, 2, 0, P + 2);
    chk("direct_is_sfr_o", 0, dsfr);
    ex(8'he5, 8'h80, 8'h00, 2, 2, 0, P + 2);
    chk("direct_is_sfr_o", 1, dsfr);
    bank = 2'd2;
    ex(8'hed, 8'h00, 8'h00, 1, 1, 0, P + 1);
    chk("ram_index_o", 16'h15, ridx);
    bank = 2'd1;
    ex(8'he7, 8'h00, 8'h00, 2, 1, 0, P + 1);
    chk("ram_index_o", 16'h09, ridx);
    $display("test addressing done");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Free-running 40 MHz clock.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Watchdog: the run needs well under a thousand cycles.
  initial begin
    #(25 * 5000);
    err_count++;
    results();
  end
  // Main sequence, with all inputs defined from time zero.
  initial begin
    {rst_b, valid, cy, bitv, wr, rd, bank} = '0;
    {op, op1, op2, acc, cmpv, decv, addr, wdata} = '0;
    repeat (10) @(posedge clk);
    #1 rst_b = 1'b1;
    t_acc();
    t_moves();
    t_ptr();
    t_cond();
    t_jump();
    t_addr();
    results();
  end
endmodule
`default_nettype wire
